// ---- shared/dagen_pkg.sv ----
// Constants shared by the data-address generator and its users
package dagen_pkg;

  // Data space geometry: 512 pages of 128 words
  localparam int          DAG_ADDR_W      = 16;
  localparam int          DAG_PAGE_W      = 9;
  localparam int          DAG_OFFS_W      = 7;
  localparam int          DAG_SEL_W       = 3;
  localparam int          DAG_NUM_PTR     = 8;
  localparam int          DAG_PAGE_WORDS  = 128;
  localparam int          DAG_NUM_PAGES   = 512;
  localparam logic [15:0] DAG_LAST_PAGE_LO = 16'hFF80;

  // Page 0 regions (word address inside the page)
  localparam logic [15:0] DAG_MMR_LAST     = 16'h0007;
  localparam logic [15:0] DAG_TEST_LAST    = 16'h005F;
  localparam logic [15:0] DAG_PAGE0_LAST   = 16'h007F;
  localparam logic [1:0]  DAG_REG_OTHER    = 2'h0;
  localparam logic [1:0]  DAG_REG_MMR      = 2'h1;
  localparam logic [1:0]  DAG_REG_TEST     = 2'h2;
  localparam logic [1:0]  DAG_REG_SCRATCH  = 2'h3;

  // Pointer arithmetic operations
  localparam logic [2:0]  DAG_OP_NONE     = 3'h0;
  localparam logic [2:0]  DAG_OP_INC      = 3'h1;
  localparam logic [2:0]  DAG_OP_DEC      = 3'h2;
  localparam logic [2:0]  DAG_OP_ADD_IDX  = 3'h3;
  localparam logic [2:0]  DAG_OP_SUB_IDX  = 3'h4;
  localparam logic [2:0]  DAG_OP_ADD_REV  = 3'h5;
  localparam logic [2:0]  DAG_OP_SUB_REV  = 3'h6;

  // Compare conditions (current pointer against pointer 0)
  localparam logic [1:0]  DAG_CMP_EQ      = 2'h0;
  localparam logic [1:0]  DAG_CMP_LT      = 2'h1;
  localparam logic [1:0]  DAG_CMP_GT      = 2'h2;
  localparam logic [1:0]  DAG_CMP_NE      = 2'h3;

  // Register byte offsets on the bus
  localparam int          DAG_BUS_ADDR_W  = 6;
  localparam logic [5:0]  DAG_OFF_STATUS0 = 6'h00;
  localparam logic [5:0]  DAG_OFF_STATUS1 = 6'h04;
  localparam logic [5:0]  DAG_OFF_PTR0    = 6'h20;

  // Status word field positions
  localparam int          DAG_SEL_LSB     = 13;
  localparam int          DAG_PAGE_LSB    = 0;
  localparam int          DAG_MAP_BIT     = 12;

  // Values after reset
  localparam logic [15:0] DAG_PTR_RST     = 16'h0000;
  localparam logic [8:0]  DAG_PAGE_RST    = 9'h000;
  localparam logic [2:0]  DAG_SEL_RST     = 3'h0;
  localparam logic        DAG_MAP_RST     = 1'b0;

endpackage

// ---- hw/dagen_core.sv ----
// Data-address generator: page and pointer addressing with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

module dagen_core
  import dagen_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Avalon-MM slave
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Decoder requests
  input  wire logic        RD_EN,
  input  wire logic        RD_INDIRECT,
  input  wire logic        WR_EN,
  input  wire logic        WR_INDIRECT,
  input  wire logic [6:0]  OFFSET,
  input  wire logic [2:0]  PTR_OP,
  input  wire logic        SEL_LOAD,
  input  wire logic [2:0]  SEL_VALUE,
  input  wire logic        PAGE_LOAD,
  input  wire logic [8:0]  PAGE_VALUE,
  input  wire logic        CMP_EN,
  input  wire logic [1:0]  CMP_COND,
  // Memory side
  output logic      [15:0] READ_ADDR,
  output logic             READ_VALID,
  output logic      [1:0]  READ_REGION,
  output logic      [15:0] WRITE_ADDR,
  output logic             WRITE_VALID,
  output logic             CMP_FLAG,
  output logic             RAM_ZERO_IN_DATA
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] pointer_regs [DAG_NUM_PTR];
  logic [8:0]  page_pointer;
  logic [2:0]  current_pointer_select;
  logic [2:0]  pointer_select_backup;
  logic        ram_block_map_select;
  logic        bus_ack;
  logic [15:0] cur_ptr;
  logic [15:0] idx_ptr;
  logic [15:0] next_ptr;
  logic        bus_wr;
  logic [15:0] status_word_zero;
  logic [15:0] status_word_one;
  logic [15:0] direct_addr;
  logic [15:0] rd_addr_next;
  logic [15:0] wr_addr_next;

  // Mirror the 16 bits, used to turn a normal adder into a reverse-carry one
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // Page region decode of a data address
  function automatic logic [1:0] region_of(input logic [15:0] a);
    logic [1:0] r;
    r = DAG_REG_OTHER;
    if (a <= DAG_MMR_LAST) begin
      r = DAG_REG_MMR;
    end else if (a <= DAG_TEST_LAST) begin
      r = DAG_REG_TEST;
    end else if (a <= DAG_PAGE0_LAST) begin
      r = DAG_REG_SCRATCH;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address formation
  assign cur_ptr     = pointer_regs[current_pointer_select];
  assign idx_ptr     = pointer_regs[0];
  assign direct_addr = {page_pointer, OFFSET};
  assign rd_addr_next = RD_INDIRECT ? cur_ptr : direct_addr;
  assign wr_addr_next = WR_INDIRECT ? cur_ptr : direct_addr;

  // Separate read and write address buses, one new address per cycle
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      READ_ADDR   <= 16'h0000;
      READ_VALID  <= 1'b0;
      READ_REGION <= DAG_REG_OTHER;
    end else begin
      READ_VALID <= RD_EN;
      if (RD_EN) begin
        READ_ADDR   <= rd_addr_next;
        READ_REGION <= region_of(rd_addr_next);
      end
    end
  end

  // Write address bus, independent of the read bus
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      WRITE_ADDR  <= 16'h0000;
      WRITE_VALID <= 1'b0;
    end else begin
      WRITE_VALID <= WR_EN;
      if (WR_EN) begin
        WRITE_ADDR <= wr_addr_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer arithmetic; index is pointer 0
  always_comb begin
    unique case (PTR_OP)
      DAG_OP_INC:     next_ptr = cur_ptr + 16'h0001;
      DAG_OP_DEC:     next_ptr = cur_ptr - 16'h0001;
      DAG_OP_ADD_IDX: next_ptr = cur_ptr + idx_ptr;
      DAG_OP_SUB_IDX: next_ptr = cur_ptr - idx_ptr;
      // Mirrored add sends the carry from MSB down to LSB
      DAG_OP_ADD_REV: next_ptr = rev16(rev16(cur_ptr) + rev16(idx_ptr));
      DAG_OP_SUB_REV: next_ptr = rev16(rev16(cur_ptr) - rev16(idx_ptr));
      default:        next_ptr = cur_ptr;
    endcase
  end

  // Compare current pointer against pointer 0
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CMP_FLAG <= 1'b0;
    end else if (CMP_EN) begin
      unique case (CMP_COND)
        DAG_CMP_EQ: CMP_FLAG <= (cur_ptr == idx_ptr);
        DAG_CMP_LT: CMP_FLAG <= (cur_ptr < idx_ptr);
        DAG_CMP_GT: CMP_FLAG <= (cur_ptr > idx_ptr);
        DAG_CMP_NE: CMP_FLAG <= (cur_ptr != idx_ptr);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus write strobe: only at the edge where waitrequest is low
  assign bus_wr = AVS_WRITE && bus_ack;

  // Pointer registers; decoder update wins over a bus write to the same one
  generate
    for (genvar g = 0; g < DAG_NUM_PTR; g++) begin : g_ptr
      always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          pointer_regs[g] <= DAG_PTR_RST;
        end else if (PTR_OP != DAG_OP_NONE &&
                     current_pointer_select == 3'(g)) begin
          pointer_regs[g] <= next_ptr;
        end else if (bus_wr && AVS_ADDRESS == DAG_OFF_PTR0 + 6'(4 * g)) begin
          pointer_regs[g] <= AVS_WRITEDATA[15:0];
        end
      end
    end
  endgenerate

  // Selection and its backup; the decoder load beats a bus write
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      current_pointer_select <= DAG_SEL_RST;
      pointer_select_backup  <= DAG_SEL_RST;
    end else if (SEL_LOAD) begin
      current_pointer_select <= SEL_VALUE;
      pointer_select_backup  <= current_pointer_select;
    end else if (bus_wr && AVS_ADDRESS == DAG_OFF_STATUS0) begin
      current_pointer_select <= AVS_WRITEDATA[DAG_SEL_LSB +: DAG_SEL_W];
      pointer_select_backup  <= current_pointer_select;
    end else if (bus_wr && AVS_ADDRESS == DAG_OFF_STATUS1) begin
      pointer_select_backup  <= AVS_WRITEDATA[DAG_SEL_LSB +: DAG_SEL_W];
    end
  end

  // Page pointer
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      page_pointer <= DAG_PAGE_RST;
    end else if (PAGE_LOAD) begin
      page_pointer <= PAGE_VALUE;
    end else if (bus_wr && AVS_ADDRESS == DAG_OFF_STATUS0) begin
      page_pointer <= AVS_WRITEDATA[DAG_PAGE_LSB +: DAG_PAGE_W];
    end
  end

  // RAM block zero mapping: 1 puts it in data space
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ram_block_map_select <= DAG_MAP_RST;
    end else if (bus_wr && AVS_ADDRESS == DAG_OFF_STATUS1) begin
      ram_block_map_select <= AVS_WRITEDATA[DAG_MAP_BIT];
    end
  end
  assign RAM_ZERO_IN_DATA = ram_block_map_select;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state, read data latched in the first cycle
  assign status_word_zero = {current_pointer_select, 4'h0, page_pointer};
  assign status_word_one  = {pointer_select_backup, ram_block_map_select, 12'h000};
  assign AVS_WAITREQUEST  = (AVS_READ || AVS_WRITE) && !bus_ack;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (AVS_READ || AVS_WRITE) && !bus_ack;
    end
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !bus_ack) begin
      AVS_READDATA <= 32'h0000_0000;
      if (AVS_ADDRESS == DAG_OFF_STATUS0) begin
        AVS_READDATA <= {16'h0000, status_word_zero};
      end else if (AVS_ADDRESS == DAG_OFF_STATUS1) begin
        AVS_READDATA <= {16'h0000, status_word_one};
      end else if (AVS_ADDRESS >= DAG_OFF_PTR0 && AVS_ADDRESS[1:0] == 2'h0) begin
        AVS_READDATA <= {16'h0000, pointer_regs[AVS_ADDRESS[4:2]]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  direct_read_a: assert property (RD_EN && !RD_INDIRECT && !PAGE_LOAD |=>
    READ_ADDR == {$past(page_pointer), $past(OFFSET)})
    else $error("direct read address wrong");

  last_page_a: assert property (RD_EN && !RD_INDIRECT && page_pointer == 9'h1FF |=>
    READ_ADDR >= DAG_LAST_PAGE_LO)
    else $error("last page address out of range");

  indirect_write_a: assert property (WR_EN && WR_INDIRECT |=>
    WRITE_ADDR == $past(cur_ptr))
    else $error("indirect write address wrong");

  sel_backup_a: assert property (SEL_LOAD |=>
    pointer_select_backup == $past(current_pointer_select) &&
    current_pointer_select == $past(SEL_VALUE))
    else $error("selection backup wrong");

  ptr_inc_a: assert property (PTR_OP == DAG_OP_INC && !SEL_LOAD ##1 RD_EN && RD_INDIRECT
    |=> READ_ADDR == $past(cur_ptr, 2) + 16'h0001)
    else $error("increment not applied");

  bitrev_a: assert property (PTR_OP == DAG_OP_ADD_REV && !SEL_LOAD |=>
    cur_ptr == rev16(rev16($past(cur_ptr)) + rev16($past(idx_ptr))))
    else $error("reverse carry add wrong");

  rate_a: assert property (RD_EN && WR_EN |=> READ_VALID && WRITE_VALID)
    else $error("address not produced in one cycle");

  map_bit_a: assert property (bus_wr && AVS_ADDRESS == DAG_OFF_STATUS1 |=>
    RAM_ZERO_IN_DATA == $past(AVS_WRITEDATA[DAG_MAP_BIT]))
    else $error("map bit not written");

  region_a: assert property (RD_EN && RD_INDIRECT && cur_ptr >= 16'h0060 &&
    cur_ptr <= 16'h007F |=> READ_REGION == DAG_REG_SCRATCH)
    else $error("scratch region not flagged");

  wait_one_a: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest held too long");

  cmp_eq_a: assert property (CMP_EN && CMP_COND == DAG_CMP_EQ |=>
    CMP_FLAG == ($past(cur_ptr) == $past(idx_ptr)))
    else $error("compare flag wrong");

  direct_c: cover property (RD_EN && !RD_INDIRECT ##1 READ_VALID);
  bitrev_c: cover property (PTR_OP == DAG_OP_ADD_REV ##1 RD_EN && RD_INDIRECT);
  sel_c:    cover property (SEL_LOAD ##1 SEL_LOAD);
  bus_c:    cover property (AVS_READ && !AVS_WAITREQUEST);

endmodule

`default_nettype wire

// ---- verification/dagen_mem_model.sv ----
// Memory-side partner: counts addresses from both address buses and keeps the last write address
`timescale 1ns/1ps
`default_nettype none
module dagen_mem_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] read_addr,
  input  wire logic        read_valid,
  input  wire logic [15:0] write_addr,
  input  wire logic        write_valid,
  output int               rd_count,
  output int               wr_count,
  output logic      [15:0] last_wr
);
  //////////////////////////////////////////////////////////////////////////////
  // Buses taken apart so a read and a write land in one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_count <= 0;
      wr_count <= 0;
      last_wr  <= 16'h0000;
    end else begin
      if (read_valid) rd_count <= rd_count + 1;
      if (write_valid) wr_count <= wr_count + 1;
      if (write_valid) last_wr <= write_addr;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the data-address generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb
  import dagen_pkg::*;
;
  logic        clock, rst, avs_read, avs_write, avs_wait, rd_en, rd_ind, wr_en, wr_ind;
  logic        sel_load, page_load, cmp_en, cmp_flag, ram_zero, read_valid, write_valid;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [6:0]  offset;
  logic [2:0]  ptr_op, sel_value;
  logic [8:0]  page_value;
  logic [1:0]  cmp_cond, read_region;
  logic [15:0] read_addr, write_addr, last_wr, d, e;
  int          mismatches, checks_done, rd_count, wr_count, cyc;

  dagen_core i_dut (.CLOCK(clock), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_wait), .RD_EN(rd_en), .RD_INDIRECT(rd_ind), .WR_EN(wr_en),
    .WR_INDIRECT(wr_ind), .OFFSET(offset), .PTR_OP(ptr_op), .SEL_LOAD(sel_load),
    .SEL_VALUE(sel_value), .PAGE_LOAD(page_load), .PAGE_VALUE(page_value), .CMP_EN(cmp_en),
    .CMP_COND(cmp_cond), .READ_ADDR(read_addr), .READ_VALID(read_valid),
    .READ_REGION(read_region), .WRITE_ADDR(write_addr), .WRITE_VALID(write_valid),
    .CMP_FLAG(cmp_flag), .RAM_ZERO_IN_DATA(ram_zero));
  dagen_mem_model i_mem (.clock(clock), .rst(rst), .read_addr(read_addr),
    .read_valid(read_valid), .write_addr(write_addr), .write_valid(write_valid),
    .rd_count(rd_count), .wr_count(wr_count), .last_wr(last_wr));

  //////////////////////////////////////////////////////////////////////////////
  // Expected pointer arithmetic, reverse carry done on mirrored operands
  function automatic logic [15:0] rv(input logic [15:0] v);
    return {<<{v}};
  endfunction
  function automatic logic [15:0] nxt(input logic [2:0] op, input logic [15:0] v, x);
    case (op)
      DAG_OP_INC: return v + 16'h0001;
      DAG_OP_DEC: return v - 16'h0001;
      DAG_OP_ADD_IDX: return v + x;
      DAG_OP_SUB_IDX: return v - x;
      DAG_OP_ADD_REV: return rv(rv(v) + rv(x));
      default: return rv(rv(v) - rv(x));
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus cycles; the wait count is unbounded here, the watchdog cuts a hang
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {16'h0000, wd};
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest and read data are both taken at the same rising edge
    @(posedge clock);
    while (avs_wait !== 1'b0) begin
      @(posedge clock);
    end
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // One decoder cycle; outputs checked one edge later
  task automatic dec(input logic ri, we, wi, input logic [2:0] op, input logic [6:0] off);
    @(posedge clock);
    rd_en <= 1'b1;
    rd_ind <= ri;
    wr_en <= we;
    wr_ind <= wi;
    ptr_op <= op;
    offset <= off;
    @(posedge clock);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    ptr_op <= DAG_OP_NONE;
    #1;
  endtask
  task automatic ctl(input logic pg, input logic [8:0] v);
    @(posedge clock);
    page_load <= pg;
    sel_load <= !pg;
    page_value <= v;
    sel_value <= v[2:0];
    @(posedge clock);
    page_load <= 1'b0;
    sel_load <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, (i < 2) ? 6'(i * 4) : (i < 10) ? 6'(32 + 4 * (i - 2)) : 6'h10, 16'h0000, d);
      `CHK("reset_reg", 16'h0000, d)
    end
    `CHK("reset_map", 1'b0, ram_zero)
  endtask
  task automatic t_direct();
    logic [8:0]  pg [4] = '{9'h000, 9'h1FF, 9'h0AA, 9'h000};
    logic [6:0]  of [4] = '{7'h05, 7'h00, 7'h7F, 7'h60};
    logic [1:0]  rg [4] = '{DAG_REG_MMR, DAG_REG_OTHER, DAG_REG_OTHER, DAG_REG_SCRATCH};
    for (int i = 0; i < 4; i++) begin
      ctl(1'b1, pg[i]);
      dec(1'b0, 1'b1, 1'b0, DAG_OP_NONE, of[i]);
      `CHK("direct_rd", {pg[i], of[i]}, read_addr)
      `CHK("direct_wr", {pg[i], of[i]}, write_addr)
      `CHK("region", rg[i], read_region)
    end
    dec(1'b0, 1'b0, 1'b0, DAG_OP_NONE, 7'h08);
    `CHK("test_area", DAG_REG_TEST, read_region)
  endtask
  task automatic t_ptrs();
    // Pointer 0 lands in the scratch area so the indirect region decode is exercised
    for (int i = 0; i < 8; i++) bus(1'b1, 6'(32 + 4 * i), 16'(16'h1111 * i + 16'h0060), d);
    for (int i = 1; i < 9; i++) begin
      ctl(1'b0, 9'(i % 8));
      dec(1'b1, 1'b1, 1'b1, DAG_OP_NONE, 7'h00);
      `CHK("indirect", 16'(16'h1111 * (i % 8) + 16'h0060), read_addr)
      `CHK("indirect_wr", 16'(16'h1111 * (i % 8) + 16'h0060), write_addr)
      `CHK("ind_region", (i % 8 == 0) ? DAG_REG_SCRATCH : DAG_REG_OTHER, read_region)
      bus(1'b0, DAG_OFF_STATUS1, 16'h0000, d);
      `CHK("backup", 3'(i - 1), d[15:13])
    end
  endtask
  task automatic t_arith();
    logic [3:0] ex [2] = '{4'b0001, 4'b1010};
    bus(1'b1, DAG_OFF_PTR0, 16'h0008, d);
    bus(1'b1, 6'h24, 16'h0008, d);
    ctl(1'b0, 9'h001);
    e = 16'h0008;
    for (int op = 1; op < 7; op++) begin
      dec(1'b1, 1'b0, 1'b0, 3'(op), 7'h00);
      `CHK("ptr_before_op", e, read_addr)
      e = nxt(3'(op), e, 16'h0008);
    end
    bus(1'b0, 6'h24, 16'h0000, d);
    `CHK("ptr_after_ops", e, d)
    for (int k = 0; k < 2; k++) begin
      if (k == 1) bus(1'b1, 6'h24, 16'h0003, d);
      for (int c = 0; c < 4; c++) begin
        @(posedge clock);
        cmp_en <= 1'b1;
        cmp_cond <= 2'(c);
        @(posedge clock);
        cmp_en <= 1'b0;
        #1;
        `CHK("compare", ex[k][c], cmp_flag)
      end
    end
  endtask
  task automatic t_pipe();
    bus(1'b1, 6'h24, 16'h0040, d);
    ctl(1'b1, 9'h123);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      rd_en <= (k < 3);
      rd_ind <= 1'b1;
      wr_en <= (k < 3);
      wr_ind <= 1'b0;
      offset <= 7'(k);
      ptr_op <= (k < 3) ? DAG_OP_INC : DAG_OP_NONE;
      #1;
      if (k > 0) `CHK("pipe_rd", 16'(16'h0040 + k - 1), read_addr)
      if (k > 0) `CHK("pipe_wr", {9'h123, 7'(k - 1)}, write_addr)
    end
    // Last write address reaches the memory model one edge after the bus shows it
    @(posedge clock);
    #1;
    `CHK("mem_wr", 16'h9182, last_wr)
    `CHK("mem_rd_count", 22, rd_count)
    `CHK("mem_wr_count", 15, wr_count)
  endtask
  task automatic t_map();
    bus(1'b1, DAG_OFF_STATUS1, 16'h1000, d);
    @(posedge clock);
    `CHK("map_data", 1'b1, ram_zero)
    bus(1'b0, DAG_OFF_STATUS1, 16'h0000, d);
    `CHK("map_field", 1'b1, d[12])
    bus(1'b1, DAG_OFF_STATUS1, 16'h0000, d);
    @(posedge clock);
    `CHK("map_prog", 1'b0, ram_zero)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clock);
      cyc++;
      if (cyc == 4000) begin
        mismatches++;
        conclude();
      end
    end
  end
  initial begin
    {avs_read, avs_write, rd_en, rd_ind, wr_en, wr_ind, sel_load, page_load, cmp_en} = '0;
    {avs_address, avs_writedata, offset, ptr_op, sel_value, page_value, cmp_cond} = '0;
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_direct();
    t_ptrs();
    t_arith();
    t_pipe();
    t_map();
    conclude();
  end
endmodule
`default_nettype wire
